// File: gpp_pkg.sv
// Package for the 8-bit general-purpose port: register map, fields, types.
// How it works
// - Alternate function takes direction from peripheral
// - Function select picks GPIO or peripheral
// - Pin-level register returns sampled pin levels
// - Pin-level register read-only, writes ignored
// - Drive-value register read/write, resets to zero
// - Drive value reaches pin only as GPIO output
// - Zero drives low; open-drain one floats
// - Pin edges raise interrupt requests, selectable edge
// - Port A peripheral mapping per pin; this port leaves it to chip level
// - Ports C, D, H mappings; also left to chip level
// - Direction zero output, one input; reset ones
// - Two select bits decode none, 1, 2, 3
// - Open-drain bit applies; I2C forces open-drain
package gpp_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_DRIVE_VALUE = 8'h04;
    localparam logic [7:0] ADDR_DIRECTION = 8'h08;
    localparam logic [7:0] ADDR_FUNC_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_FUNC_LOW = 8'h10;
    localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h14;
    localparam logic [7:0] ADDR_EDGE_MODE = 8'h18;
    localparam logic [7:0] ADDR_EDGE_POL = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam int PIN_COUNT = 8;
    localparam logic [7:0] RST_DRIVE_VALUE = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PAD_RELEASED = 8'hFF;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ****************************************************************
    // Function select codes, high bit then low bit
    // ****************************************************************
    typedef enum logic [1:0] {
        FUNC_GPIO = 2'h0,
        FUNC_ONE = 2'h1,
        FUNC_TWO = 2'h2,
        FUNC_THREE = 2'h3
    } gpp_func_t;
    // Peripheral side of one function for all eight pins: output value and drive request
    typedef struct packed {
        logic [7:0] outValue;
        logic [7:0] outEnable;
    } gpp_periph_t;
endpackage : gpp_pkg

// File: gpp_port.sv
// Eight-pin general-purpose port with APB registers and edge interrupt.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module gpp_port
    import gpp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins: out, output enable active low, in
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOutEnN,
    // Peripherals: one set per alternate function
    input wire gpp_periph_t periphFunc1,
    input wire gpp_periph_t periphFunc2,
    input wire gpp_periph_t periphFunc3,
    input wire logic [7:0] i2cPinMask,
    input wire logic i2cEnable,
    output logic [7:0] pinToPeriph,
    output logic [7:0] funcActive,
    // Interrupt
    output logic irq
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] driveValue_reg;
    logic [7:0] direction_reg;
    logic [7:0] funcHigh_reg;
    logic [7:0] funcLow_reg;
    logic [7:0] openDrain_reg;
    logic [7:0] edgeAny_reg;
    logic [7:0] edgeRise_reg;
    logic [7:0] irqStatus_reg;
    logic [7:0] irqMask_reg;
    logic [7:0] pinLevel_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] levelPrev_reg;
    logic [7:0] irqStatus_next;
    logic [7:0] riseEvt;
    logic [7:0] fallEvt;
    logic [7:0] edgeEvt;
    logic [7:0] stable;
    logic wrEn;
    logic [7:0] wrByte;
    logic [7:0] drvOut;
    logic [7:0] drvEn;
    logic [7:0] odEff;
    logic [31:0] rdData;

    function automatic gpp_func_t pinFunc(input logic hi, input logic lo);
        return gpp_func_t'({hi, lo});
    endfunction : pinFunc

    // Decode of one register's write strobe, shared by every writable register
    function automatic logic regWrite(input logic [7:0] addr);
        return wrEn && (paddr == addr);
    endfunction : regWrite

    // Writes land only on the edge that completes the transfer, so a strobe
    // held through the wait state never clears a W1C flag twice
    assign wrEn = psel && penable && pwrite && pready;
    assign wrByte = pwdata[7:0];

    // ****************************************************************
    // Pin synchronizer, three stages, change needs stages 2 and 3 agreeing
    // ****************************************************************
    // Stage one may go metastable; only stage two ever reads it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_reg <= RST_ZERO;
        end else begin
            sync1_reg <= padIn;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync2_reg <= RST_ZERO;
        end else begin
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync3_reg <= RST_ZERO;
        end else begin
            sync3_reg <= sync2_reg;
        end
    end

    // A change counts only once stages two and three agree,
    // so a glitch of a single cycle never reaches the level register
    assign stable = ~(sync2_reg ^ sync3_reg);

    // Level is undefined by spec until sampled; zero here keeps sims clean
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinLevel_reg <= RST_ZERO;
        end else begin
            pinLevel_reg <= (stable & sync3_reg) | (~stable & pinLevel_reg);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            levelPrev_reg <= RST_ZERO;
        end else begin
            levelPrev_reg <= pinLevel_reg;
        end
    end

    // ****************************************************************
    // Software registers; pin-level offset ignores writes
    // ****************************************************************
    // The pin-level offset has no writer, so bus writes cannot reach it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            driveValue_reg <= RST_DRIVE_VALUE;
        end else if (regWrite(ADDR_DRIVE_VALUE)) begin
            driveValue_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            direction_reg <= RST_DIRECTION;
        end else if (regWrite(ADDR_DIRECTION)) begin
            direction_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            funcHigh_reg <= RST_ZERO;
        end else if (regWrite(ADDR_FUNC_HIGH)) begin
            funcHigh_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            funcLow_reg <= RST_ZERO;
        end else if (regWrite(ADDR_FUNC_LOW)) begin
            funcLow_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            openDrain_reg <= RST_ZERO;
        end else if (regWrite(ADDR_OPEN_DRAIN)) begin
            openDrain_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            edgeAny_reg <= RST_ZERO;
        end else if (regWrite(ADDR_EDGE_MODE)) begin
            edgeAny_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            edgeRise_reg <= RST_ZERO;
        end else if (regWrite(ADDR_EDGE_POL)) begin
            edgeRise_reg <= wrByte;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqMask_reg <= RST_ZERO;
        end else if (regWrite(ADDR_IRQ_MASK)) begin
            irqMask_reg <= wrByte;
        end
    end

    // ****************************************************************
    // Edge interrupts: any-edge or selected-edge per pin
    // ****************************************************************
    assign riseEvt = pinLevel_reg & ~levelPrev_reg;
    assign fallEvt = ~pinLevel_reg & levelPrev_reg;
    assign edgeEvt = (edgeAny_reg & (riseEvt | fallEvt))
        | (~edgeAny_reg & edgeRise_reg & riseEvt)
        | (~edgeAny_reg & ~edgeRise_reg & fallEvt);

    always_comb begin
        irqStatus_next = irqStatus_reg;
        if (regWrite(ADDR_IRQ_STATUS)) begin
            irqStatus_next = irqStatus_reg & ~wrByte;
        end
        // Set after clear so a same-cycle event survives
        irqStatus_next = irqStatus_next | edgeEvt;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqStatus_reg <= RST_ZERO;
        end else begin
            irqStatus_reg <= irqStatus_next;
        end
    end

    // Built from the next status so the line rises with the flag, not after it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_next & irqMask_reg);
        end
    end

    // ****************************************************************
    // Pin drive mux
    // ****************************************************************
    // The peripheral wiring per pin (timers, UART, SPI, PWM, analog) lives
    // at chip level; this block picks among the three function inputs.
    always_comb begin
        drvOut = RST_ZERO;
        drvEn = RST_ZERO;
        for (int i = 0; i < PIN_COUNT; i++) begin
            case (pinFunc(funcHigh_reg[i], funcLow_reg[i]))
                FUNC_GPIO: begin
                    drvOut[i] = driveValue_reg[i];
                    drvEn[i] = ~direction_reg[i];
                end
                FUNC_ONE: begin
                    drvOut[i] = periphFunc1.outValue[i];
                    drvEn[i] = periphFunc1.outEnable[i];
                end
                FUNC_TWO: begin
                    drvOut[i] = periphFunc2.outValue[i];
                    drvEn[i] = periphFunc2.outEnable[i];
                end
                FUNC_THREE: begin
                    drvOut[i] = periphFunc3.outValue[i];
                    drvEn[i] = periphFunc3.outEnable[i];
                end
                default: begin
                    drvOut[i] = 1'b0;
                    drvEn[i] = 1'b0;
                end
            endcase
        end
    end

    // I2C pins go open-drain while the controller is on, whatever the register says
    assign odEff = openDrain_reg | (i2cEnable ? i2cPinMask : RST_ZERO);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            padOut <= RST_ZERO;
        end else begin
            padOut <= drvOut & ~odEff;
        end
    end

    // Open-drain: a one releases the pin instead of driving high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            padOutEnN <= RST_PAD_RELEASED;
        end else begin
            padOutEnN <= ~(drvEn & ~(odEff & drvOut));
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinToPeriph <= RST_ZERO;
        end else begin
            pinToPeriph <= pinLevel_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            funcActive <= RST_ZERO;
        end else begin
            funcActive <= funcHigh_reg | funcLow_reg;
        end
    end

    // ****************************************************************
    // APB read path, one wait state
    // ****************************************************************
    always_comb begin
        rdData = RD_ZERO;
        case (paddr)
            ADDR_PIN_LEVEL: rdData[7:0] = pinLevel_reg;
            ADDR_DRIVE_VALUE: rdData[7:0] = driveValue_reg;
            ADDR_DIRECTION: rdData[7:0] = direction_reg;
            ADDR_FUNC_HIGH: rdData[7:0] = funcHigh_reg;
            ADDR_FUNC_LOW: rdData[7:0] = funcLow_reg;
            ADDR_OPEN_DRAIN: rdData[7:0] = openDrain_reg;
            ADDR_EDGE_MODE: rdData[7:0] = edgeAny_reg;
            ADDR_EDGE_POL: rdData[7:0] = edgeRise_reg;
            ADDR_IRQ_STATUS: rdData[7:0] = irqStatus_reg;
            ADDR_IRQ_MASK: rdData[7:0] = irqMask_reg;
            default: rdData = RD_ZERO;
        endcase
    end

    // Registered answer: one wait state keeps the read mux off the output path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // Read data is captured on the first access edge and stands with pready
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= RD_ZERO;
        end else begin
            prdata <= rdData;
        end
    end

    // Every offset answers, so no transfer ever reports an error
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
        end
    end
endmodule : gpp_port

// File: gpp_port_sva.sv
// Checker for port bus, pin and interrupt timing.
`timescale 1ns/1ps
module gpp_port_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt
    input wire logic [7:0] padIn,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOutEnN,
    input wire logic [7:0] pinToPeriph,
    input wire logic [7:0] i2cPinMask,
    input wire logic i2cEnable,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_no_error: assert property (!pslverr)
        else $error("pslverr raised");
    a_read_width: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read upper bits set");
    // Five quiet cycles cover the three sync stages plus the level and pinToPeriph registers
    a_sync_follow: assert property ($stable(padIn) [*5] |=> pinToPeriph == $past(padIn))
        else $error("pin level not followed");
    a_i2c_open: assert property (i2cEnable && $stable(i2cEnable) && $stable(i2cPinMask)
        |-> (padOut & ~padOutEnN & i2cPinMask) == 8'h00) else $error("i2c pin driven high");
    a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable && pwrite)
        || $past(psel && penable && pwrite, 2)) else $error("irq fell without write");
endmodule : gpp_port_sva
bind gpp_port gpp_port_sva i_gpp_port_sva (.mclk, .rst, .psel, .penable, .pwrite, .prdata,
    .pready, .pslverr, .padIn, .padOut, .padOutEnN, .pinToPeriph, .i2cPinMask, .i2cEnable, .irq);

// File: gpp_pin_model.sv
// Pin model: resolves each pad from the port driver and the outside level.
`timescale 1ns/1ps
module gpp_pin_model (
    // Port side
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOutEnN,
    // Outside world
    input wire logic [7:0] extLevel,
    output logic [7:0] padIn
);
    // A released pad shows the outside level, so floats never read as a port value
    assign padIn = (padOut & ~padOutEnN) | (extLevel & padOutEnN);
endmodule : gpp_pin_model

// File: gpp_port_tb.sv
// Testbench for the eight-pin general-purpose port.
`timescale 1ns/1ps
module gpp_port_tb
    import gpp_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic i2cEnable = 1'b0, pready, pslverr, irq;
    logic [7:0] paddr = 8'h00, extLevel = 8'h00, i2cPinMask = 8'h00;
    logic [7:0] padIn, padOut, padOutEnN, pinToPeriph, funcActive;
    logic [31:0] pwdata = 32'h00000000, prdata, rdata;
    gpp_periph_t periphFunc1 = '0, periphFunc2 = '0, periphFunc3 = '0;
    int failures = 0, samplesChecked = 0, cycles = 0;
    always #50 mclk = ~mclk;
    gpp_port i_gpp_port (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .padIn, .padOut, .padOutEnN, .periphFunc1, .periphFunc2,
        .periphFunc3, .i2cPinMask, .i2cEnable, .pinToPeriph, .funcActive, .irq);
    gpp_pin_model i_gpp_pin_model (.padOut, .padOutEnN, .extLevel, .padIn);
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        samplesChecked++;
        if (got !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, e, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No wait limit here: the cycle ceiling below ends a hung transfer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
        apb(1'b0, a, 32'h00000000);
        chk(name, e, rdata);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic test_reset;
        rd(ADDR_DRIVE_VALUE, 32'h00000000, "drive");
        rd(ADDR_DIRECTION, {24'h000000, RST_DIRECTION}, "dir");
        rd(8'h3C, RD_ZERO, "unmapped");
        chk("enN", 32'h000000FF, padOutEnN);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_drive;
        wr(ADDR_DRIVE_VALUE, 8'hA5);
        rd(ADDR_DRIVE_VALUE, 32'h000000A5, "drive");
        chk("enN in", 32'h000000FF, padOutEnN);
        wr(ADDR_DIRECTION, 8'hF0);
        wt(3);
        chk("enN out", 32'h000000F0, padOutEnN);
        chk("out", 32'h00000005, padOut & ~padOutEnN);
        wr(ADDR_OPEN_DRAIN, 8'h05);
        wt(3);
        chk("od enN", 32'h000000F5, padOutEnN);
        chk("od out", 32'h00000000, padOut & ~padOutEnN);
        wr(ADDR_OPEN_DRAIN, 8'h00);
        wr(ADDR_DIRECTION, 8'hFF);
        $display("test_drive done");
    endtask : test_drive
    task automatic test_irq;
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_IRQ_STATUS, 8'hFF);
        wr(ADDR_EDGE_MODE, 8'h01);
        extLevel <= 8'h03;
        wt(8);
        rd(ADDR_PIN_LEVEL, 32'h00000003, "level");
        chk("to periph", 32'h00000003, pinToPeriph);
        wr(ADDR_PIN_LEVEL, 8'h00);
        rd(ADDR_PIN_LEVEL, 32'h00000003, "level ro");
        rd(ADDR_IRQ_STATUS, 32'h00000001, "rise");
        chk("irq", 32'h00000001, irq);
        wr(ADDR_IRQ_STATUS, 8'h01);
        extLevel <= 8'h00;
        wt(8);
        rd(ADDR_IRQ_STATUS, 32'h00000003, "fall");
        wr(ADDR_IRQ_STATUS, 8'h03);
        wt(2);
        chk("irq clr", 32'h00000000, irq);
        wr(ADDR_IRQ_MASK, 8'h00);
        extLevel <= 8'h01;
        wt(8);
        chk("irq masked", 32'h00000000, irq);
        wr(ADDR_EDGE_POL, 8'h02);
        wr(ADDR_IRQ_STATUS, 8'hFF);
        extLevel <= 8'h03;
        wt(8);
        rd(ADDR_IRQ_STATUS, 32'h00000002, "rise only");
        wr(ADDR_IRQ_STATUS, 8'hFF);
        extLevel <= 8'h01;
        wt(8);
        rd(ADDR_IRQ_STATUS, 32'h00000000, "fall ignored");
        $display("test_irq done");
    endtask : test_irq
    task automatic test_func;
        periphFunc1 <= '{outValue: 8'h81, outEnable: 8'h81};
        periphFunc2 <= '{outValue: 8'h00, outEnable: 8'h01};
        periphFunc3 <= '{outValue: 8'hFF, outEnable: 8'h00};
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_FUNC_HIGH, {7'h00, c[1]});
            wr(ADDR_FUNC_LOW, {7'h00, c[0]});
            wt(3);
            chk("active", c != 0, funcActive[0]);
            chk("enN", c == 0 || c == 3, padOutEnN[0]);
            chk("out", c == 1, padOut[0] & ~padOutEnN[0]);
        end
        wr(ADDR_FUNC_HIGH, 8'h00);
        wr(ADDR_FUNC_LOW, 8'h80);
        wt(3);
        chk("pin7", 32'h00000001, {padOutEnN[7], padOut[7]});
        i2cPinMask <= 8'h80;
        i2cEnable <= 1'b1;
        wt(3);
        chk("i2c", 32'h00000001, padOutEnN[7]);
        $display("test_func done");
    endtask : test_func
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        test_reset();
        test_drive();
        test_irq();
        test_func();
        print_verdict();
    end
endmodule : gpp_port_tb
